/* File: logic/flash_burst_pkg.sv */
`default_nettype none
package flash_burst_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BANKS  = 4;
  localparam int CNT_W  = 5;
  localparam int SLOW_W = 6;

  localparam logic [5:0] BOUND_LAST_WORD = 6'h3f;
  localparam logic [5:0] BOUND_PRE_WORD  = 6'h3e;

  // One bit above the wait-state field, so fifteen waits plus extras cannot wrap
  localparam logic [CNT_W-1:0] BOUND_CYCLES        = 5'h02;
  localparam logic [CNT_W-1:0] REDUCED_START_EXTRA = 5'h02;
  localparam logic [CNT_W-1:0] ODD_START_EXTRA     = 5'h01;
  localparam logic [CNT_W-1:0] NO_EXTRA            = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO            = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE             = 5'h01;

  localparam logic [ADDR_W-1:0] BANK_B_BASE = 22'h080000;
  localparam logic [ADDR_W-1:0] BANK_C_BASE = 22'h200000;
  localparam logic [ADDR_W-1:0] BANK_D_BASE = 22'h380000;

  // Word returned while a bank is busy programming or erasing
  localparam logic [DATA_W-1:0] STATUS_WORD = 16'h0080;

  // Burst clock floor, in MHz as specified, and the matching period in mclk cycles
  localparam longint MCLK_HZ       = 250000000;
  localparam longint MIN_BCLK_MHZ  = 6;
  localparam longint MIN_BCLK_HZ   = MIN_BCLK_MHZ * 1000000;
  localparam logic [SLOW_W-1:0] SLOW_LIMIT = SLOW_W'(MCLK_HZ / MIN_BCLK_HZ);
  localparam logic [SLOW_W-1:0] SLOW_MAX   = 6'h3f;
  localparam logic [SLOW_W-1:0] SLOW_ZERO  = 6'h00;
  localparam logic [SLOW_W-1:0] SLOW_ONE   = 6'h01;

  typedef enum logic [1:0] {
    MODE_CONT   = 2'h0,
    MODE_WRAP8  = 2'h1,
    MODE_WRAP16 = 2'h2,
    MODE_WRAP32 = 2'h3
  } burst_mode_t;

  typedef struct packed {
    logic        sync_en;
    logic        falling_edge;
    logic        rdy_early;
    burst_mode_t mode;
    logic [3:0]  wait_states;
  } cfg_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic address_valid_strobe_n;
  } bus_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_INIT   = 3'h1,
    ST_STREAM = 3'h2,
    ST_HOLD   = 3'h3,
    ST_STATUS = 3'h4
  } burst_state_t;

  function automatic logic [1:0] bank_of(input logic [ADDR_W-1:0] a);
    if (a < BANK_B_BASE)
      bank_of = 2'h0;
    else if (a < BANK_C_BASE)
      bank_of = 2'h1;
    else if (a < BANK_D_BASE)
      bank_of = 2'h2;
    else
      bank_of = 2'h3;
  endfunction : bank_of

  function automatic logic [ADDR_W-1:0] next_burst_addr(input logic [ADDR_W-1:0] a,
                                                        input burst_mode_t mode);
    unique case (mode)
      MODE_CONT:   next_burst_addr = ADDR_W'(a + 22'h000001);
      MODE_WRAP8:  next_burst_addr = {a[ADDR_W-1:3], 3'(a[2:0] + 3'h1)};
      MODE_WRAP16: next_burst_addr = {a[ADDR_W-1:4], 4'(a[3:0] + 4'h1)};
      MODE_WRAP32: next_burst_addr = {a[ADDR_W-1:5], 5'(a[4:0] + 5'h01)};
    endcase
  endfunction : next_burst_addr

endpackage : flash_burst_pkg
`default_nettype wire

/* File: logic/flash_array.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_array #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input  wire logic          i_rst_n,
  input  wire logic          i_wclk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_rclk_a,
  input  wire logic          i_ren_a,
  input  wire logic [AW-1:0] i_raddr_a,
  output logic      [DW-1:0] o_rdata_a,
  input  wire logic          i_rclk_b,
  input  wire logic          i_ren_b,
  input  wire logic [AW-1:0] i_raddr_b,
  output logic      [DW-1:0] o_rdata_b
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_wclk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
  end

  // Read data only moves on an enabled read, so a stalled reader keeps its word
  always_ff @(posedge i_rclk_a or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata_a <= '0;
    else if (i_ren_a)
      o_rdata_a <= mem[i_raddr_a];
  end

  always_ff @(posedge i_rclk_b or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata_b <= '0;
    else if (i_ren_b)
      o_rdata_b <= mem[i_raddr_b];
  end

endmodule : flash_array
`default_nettype wire

/* File: logic/flash_burst_read_interface.sv */
// How it works
// - After reset the part serves asynchronous reads until synchronous mode is chosen.
// - Once configuration is loaded with sync enabled, only synchronous reads are served.
// - First word after the initial latency, then one word per active edge.
// - Continuous burst adds two wait cycles after each 3Fh word, ready low.
// - Standard parts skip that first crossing when the start was 3Eh or 3Fh.
// - Reduced parts add two initial cycles for 3Eh/3Fh starts, skip crossing.
// - Continuous burst wraps at the top; ends on deselect, reset or new address.
// - Crossing into an idle bank costs the same two extra cycles.
// - Crossing into a busy bank returns status, clock ignored until new address.
// - A burst clock below 6 MHz adds wait cycles with ready low.
// - Wrap modes of 8, 16, 32 words wrap inside their aligned group.
// - Wrap modes never cross the 64-word boundary, so no boundary waits.
// - Output enable high with chip selected suspends the burst, state kept.
// - Suspension works during the initial access and during data output.
// - Output enable low again resumes the burst at the next active edge.
// - Ready is enabled by chip select only, driven while outputs are off.
// - Configuration holds wait states, mode, edge, ready timing, sync enable.
// - Reduced parts mark the first word by ready rising after output enable.
// - Standard parts delay ready and data one cycle for odd start addresses.
// - The identification output reports whether reduced handshaking is fitted.
// - The rising clock edge is active unless configured otherwise.
// - Address strobe low with chip selected latches the burst start address.
// - Ready is low while data is not valid and high when it is; with rdy_early set it leads the data by one edge.
`timescale 1ns/1ps
`default_nettype none
module flash_burst_read_interface #(
  parameter logic       REDUCED_WS = 1'b1,
  parameter int         MEM_AW     = flash_burst_pkg::ADDR_W,
  parameter logic [3:0] SLOW_EXTRA = 4'h1
) (
  input  wire logic                                  i_mclk,
  input  wire logic                                  i_rst_n,
  input  wire logic                                  i_bclk,
  input  wire logic [flash_burst_pkg::ADDR_W-1:0]    i_addr,
  input  wire flash_burst_pkg::bus_ctl_t             i_ctl,
  input  wire flash_burst_pkg::cfg_t                 i_cfg,
  input  wire logic                                  i_cfg_load,
  input  wire logic [flash_burst_pkg::BANKS-1:0]     i_bank_busy,
  input  wire logic                                  i_wr_en,
  input  wire logic [flash_burst_pkg::ADDR_W-1:0]    i_wr_addr,
  input  wire logic [flash_burst_pkg::DATA_W-1:0]    i_wr_data,
  output logic      [flash_burst_pkg::DATA_W-1:0]    o_dq,
  output logic                                       o_dq_oe,
  output logic                                       o_rdy,
  output logic                                       o_rdy_oe,
  output logic                                       o_handshake_id
);

  import flash_burst_pkg::*;

  // Core clock domain state
  cfg_t              cfg_q;
  cfg_t              next_cfg;
  bus_ctl_t          ctl_s1;
  bus_ctl_t          ctl_s2;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [ADDR_W-1:0] aaddr;
  logic [ADDR_W-1:0] next_aaddr;
  logic              async_rd;
  logic              async_oe;
  logic              next_async_oe;
  logic              bclk_s1;
  logic              bclk_s2;
  logic              bclk_s3;
  logic [SLOW_W-1:0] slow_cnt;
  logic [SLOW_W-1:0] next_slow_cnt;
  logic              slow_m;
  logic              next_slow_m;
  logic              handshake_id;

  // Link clock domain state
  logic              link_clk;
  cfg_t              cfg_l1;
  cfg_t              cfg_l2;
  logic [BANKS-1:0]  busy_l1;
  logic [BANKS-1:0]  busy_l2;
  logic              slow_l1;
  logic              slow_l2;
  burst_state_t      state;
  burst_state_t      next_state;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] next_ptr;
  logic [ADDR_W-1:0] nxt;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [CNT_W-1:0]  extra;
  logic              skip;
  logic              next_skip;
  logic              rdy;
  logic              next_rdy;
  logic              rdy_oe;
  logic              next_rdy_oe;
  logic              dq_oe_l;
  logic              next_dq_oe_l;
  logic              status_l;
  logic              next_status_l;
  logic              emit;
  logic              soon;
  logic              ce_act;
  logic              oe_act;

  logic [DATA_W-1:0] rdata_a;
  logic [DATA_W-1:0] rdata_b;

  flash_array #(
    .AW (MEM_AW),
    .DW (DATA_W)
  ) u_array (
    .i_rst_n   (i_rst_n),
    .i_wclk    (i_mclk),
    .i_we      (i_wr_en),
    .i_waddr   (i_wr_addr[MEM_AW-1:0]),
    .i_wdata   (i_wr_data),
    .i_rclk_a  (i_mclk),
    .i_ren_a   (async_rd),
    .i_raddr_a (aaddr[MEM_AW-1:0]),
    .o_rdata_a (rdata_a),
    .i_rclk_b  (link_clk),
    .i_ren_b   (emit),
    .i_raddr_b (ptr[MEM_AW-1:0]),
    .o_rdata_b (rdata_b)
  );

  // Core domain: configuration, asynchronous reads, burst clock rate watch
  always_comb
  begin
    next_cfg      = i_cfg_load ? i_cfg : cfg_q;
    async_rd      = !cfg_q.sync_en && !ctl_s2.ce_n && !ctl_s2.oe_n
                    && ctl_s2.we_n;
    next_aaddr    = !ctl_s2.address_valid_strobe_n ? addr_s2 : aaddr;
    next_async_oe = async_rd;
    if (ctl_s2.ce_n)
    begin
      // The clock stops between frames; that gap must not count as a slow clock
      next_slow_cnt = SLOW_ZERO;
      next_slow_m   = 1'b0;
    end
    else if (bclk_s2 && !bclk_s3)
    begin
      next_slow_cnt = SLOW_ZERO;
      next_slow_m   = slow_cnt > SLOW_LIMIT;
    end
    else
    begin
      // Saturates, so a stopped burst clock simply reads as slow
      next_slow_cnt = (slow_cnt == SLOW_MAX) ? slow_cnt : SLOW_W'(slow_cnt + SLOW_ONE);
      next_slow_m   = slow_m || (slow_cnt > SLOW_LIMIT);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_q        <= '0;
      ctl_s1       <= '1;
      ctl_s2       <= '1;
      addr_s1      <= '0;
      addr_s2      <= '0;
      aaddr        <= '0;
      async_oe     <= 1'b0;
      bclk_s1      <= 1'b0;
      bclk_s2      <= 1'b0;
      bclk_s3      <= 1'b0;
      slow_cnt     <= SLOW_ZERO;
      slow_m       <= 1'b0;
      handshake_id <= 1'b0;
    end
    else
    begin
      cfg_q        <= next_cfg;
      ctl_s1       <= i_ctl;
      ctl_s2       <= ctl_s1;
      addr_s1      <= i_addr;
      addr_s2      <= addr_s1;
      aaddr        <= next_aaddr;
      async_oe     <= next_async_oe;
      bclk_s1      <= i_bclk;
      bclk_s2      <= bclk_s1;
      bclk_s3      <= bclk_s2;
      slow_cnt     <= next_slow_cnt;
      slow_m       <= next_slow_m;
      handshake_id <= REDUCED_WS;
    end
  end

  // Edge select is a clock inversion; change it only with the chip deselected
  assign link_clk = i_bclk ^ cfg_q.falling_edge;

  // Link domain: burst engine
  always_comb
  begin
    ce_act        = !i_ctl.ce_n;
    oe_act        = !i_ctl.oe_n;
    next_state    = state;
    next_ptr      = ptr;
    next_cnt      = cnt;
    next_skip     = skip;
    next_status_l = status_l;
    emit          = 1'b0;
    nxt           = next_burst_addr(ptr, cfg_l2.mode);
    if (REDUCED_WS)
      extra = (i_addr[5:0] == BOUND_PRE_WORD || i_addr[5:0] == BOUND_LAST_WORD)
              ? REDUCED_START_EXTRA : NO_EXTRA;
    else
      extra = i_addr[0] ? ODD_START_EXTRA : NO_EXTRA;
    if (!ce_act)
    begin
      next_state    = ST_IDLE;
      next_status_l = 1'b0;
    end
    else if (!i_ctl.address_valid_strobe_n && i_ctl.we_n && cfg_l2.sync_en)
    begin
      next_ptr      = i_addr;
      next_cnt      = CNT_W'(cfg_l2.wait_states + extra);
      next_skip     = i_addr[5:0] == BOUND_PRE_WORD
                      || i_addr[5:0] == BOUND_LAST_WORD;
      next_status_l = i_bank_busy_l(i_addr);
      next_state    = next_status_l ? ST_STATUS : ST_INIT;
    end
    else if (!oe_act)
    begin
      // Suspended: pointer, count and held word stay put
      next_state = state;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          next_state = ST_IDLE;
        ST_INIT:
          if (cnt == CNT_ZERO)
            emit = 1'b1;
          else
            next_cnt = CNT_W'(cnt - CNT_ONE);
        ST_STREAM:
          emit = 1'b1;
        ST_HOLD:
          if (cnt == CNT_ONE)
            next_state = ST_STREAM;
          else
            next_cnt = CNT_W'(cnt - CNT_ONE);
        ST_STATUS:
        begin
          next_state    = ST_STATUS;
          next_status_l = 1'b1;
        end
        default:
          next_state = ST_IDLE;
      endcase
      if (emit)
      begin
        next_ptr   = nxt;
        next_state = ST_STREAM;
        if (cfg_l2.mode == MODE_CONT && ptr[5:0] == BOUND_LAST_WORD)
        begin
          next_skip = 1'b0;
          if (i_bank_busy_l(nxt))
          begin
            // Status shows from the next edge, so the last array word is not lost
            next_state    = ST_STATUS;
          end
          else if (!skip || bank_of(nxt) != bank_of(ptr))
          begin
            next_state = ST_HOLD;
            next_cnt   = BOUND_CYCLES;
          end
          else if (slow_l2)
          begin
            next_state = ST_HOLD;
            next_cnt   = CNT_W'(SLOW_EXTRA);
          end
        end
        else if (slow_l2)
        begin
          next_state = ST_HOLD;
          next_cnt   = CNT_W'(SLOW_EXTRA);
        end
      end
    end
    soon = next_state == ST_STREAM || (next_state == ST_INIT && next_cnt == CNT_ZERO);
    if (!ce_act)
      next_rdy = 1'b0;
    else if (next_status_l)
      next_rdy = 1'b1;
    else if (cfg_l2.rdy_early)
      next_rdy = soon && oe_act;
    else
      next_rdy = emit;
    next_rdy_oe  = ce_act;
    next_dq_oe_l = ce_act && oe_act && cfg_l2.sync_en;
  end

  // Busy flag of the bank that holds an address, from the synchronised busy bits
  function automatic logic i_bank_busy_l(input logic [ADDR_W-1:0] a);
    i_bank_busy_l = busy_l2[bank_of(a)];
  endfunction : i_bank_busy_l

  always_ff @(posedge link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_l1   <= '0;
      cfg_l2   <= '0;
      busy_l1  <= '0;
      busy_l2  <= '0;
      slow_l1  <= 1'b0;
      slow_l2  <= 1'b0;
      state    <= ST_IDLE;
      ptr      <= '0;
      cnt      <= CNT_ZERO;
      skip     <= 1'b0;
      rdy      <= 1'b0;
      rdy_oe   <= 1'b0;
      dq_oe_l  <= 1'b0;
      status_l <= 1'b0;
    end
    else
    begin
      // Config is quasi-static; per-bit syncing is safe only with the chip deselected
      cfg_l1   <= cfg_q;
      cfg_l2   <= cfg_l1;
      busy_l1  <= i_bank_busy;
      busy_l2  <= busy_l1;
      slow_l1  <= slow_m;
      slow_l2  <= slow_l1;
      state    <= next_state;
      ptr      <= next_ptr;
      cnt      <= next_cnt;
      skip     <= next_skip;
      rdy      <= next_rdy;
      rdy_oe   <= next_rdy_oe;
      dq_oe_l  <= next_dq_oe_l;
      status_l <= next_status_l;
    end
  end

  // Read path is picked by the loaded mode; both sources are registers
  assign o_dq           = cfg_q.sync_en ? (status_l ? STATUS_WORD : rdata_b) : rdata_a;
  assign o_dq_oe        = cfg_q.sync_en ? dq_oe_l : async_oe;
  assign o_rdy          = rdy;
  assign o_rdy_oe       = rdy_oe;
  assign o_handshake_id = handshake_id;

endmodule : flash_burst_read_interface
`default_nettype wire

/* File: testbench/flash_burst_read_interface_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_burst_checker #(
  parameter logic REDUCED_WS = 1'b1
) (
  input wire logic                                 i_mclk,
  input wire logic                                 i_rst_n,
  input wire logic                                 i_bclk,
  input wire logic [flash_burst_pkg::ADDR_W-1:0]   i_addr,
  input wire flash_burst_pkg::bus_ctl_t            i_ctl,
  input wire flash_burst_pkg::cfg_t                i_cfg,
  input wire logic [flash_burst_pkg::BANKS-1:0]    i_bank_busy,
  input wire logic [flash_burst_pkg::DATA_W-1:0]   o_dq,
  input wire logic                                 o_rdy,
  input wire logic                                 o_rdy_oe,
  input wire logic                                 o_handshake_id
);
  import flash_burst_pkg::*;
  logic              armed;
  logic              skip;
  logic              take;
  logic              cont;
  logic [4:0]        cnt;
  logic [4:0]        lat;
  logic [ADDR_W-1:0] trk;
  assign take = !i_ctl.ce_n && i_ctl.we_n && !i_ctl.address_valid_strobe_n;
  assign cont = i_cfg.mode == MODE_CONT && !i_ctl.oe_n && !i_ctl.ce_n && i_bank_busy == '0;
  // Only edges with outputs on count, since a suspended start keeps its latency
  assign lat = {1'b0, i_cfg.wait_states} +
               (REDUCED_WS ? {3'h0, (trk[5:1] == 5'h1f), 1'b0} : {4'h0, trk[0]});
  always_ff @(posedge i_bclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      armed <= 1'b0;
      skip  <= 1'b0;
      cnt   <= 5'h00;
      trk   <= '0;
    end
    else if (take)
    begin
      armed <= 1'b1;
      skip  <= i_addr[5:1] == 5'h1f;
      cnt   <= 5'h00;
      trk   <= i_addr;
    end
    else
    begin
      if (armed && !i_ctl.oe_n)
        cnt <= cnt + 5'h01;
      if (o_rdy)
      begin
        armed <= 1'b0;
        trk   <= trk + 22'h000001;
        skip  <= skip && trk[5:0] != BOUND_LAST_WORD;
      end
    end
  end
  chk_rdy_oe_ce:
    assert property (@(posedge i_bclk) disable iff (!i_rst_n) o_rdy_oe == !$past(i_ctl.ce_n))
    else $error("ready enable does not follow chip select");
  chk_idle_quiet:
    assert property (@(posedge i_bclk) disable iff (!i_rst_n) $past(i_ctl.ce_n) |-> !o_rdy)
    else $error("ready high while deselected");
  chk_suspend_hold:
    assert property (@(posedge i_bclk) disable iff (!i_rst_n)
      $past(i_ctl.oe_n) && $past(!i_ctl.ce_n) && !i_ctl.ce_n |-> $stable(o_dq) && !o_rdy)
    else $error("burst moved while suspended");
  chk_first_word:
    assert property (@(posedge i_bclk) disable iff (!i_rst_n) armed && o_rdy |-> cnt == lat + 5'h01)
    else $error("first word at wrong edge");
  chk_bound_hold:
    assert property (@(posedge i_bclk) disable iff (!i_rst_n)
      o_rdy && cont && trk[5:0] == BOUND_LAST_WORD && !skip |=> !o_rdy ##1 !o_rdy ##1 o_rdy)
    else $error("boundary wait not two cycles");
  chk_bound_skip:
    assert property (@(posedge i_bclk) disable iff (!i_rst_n)
      o_rdy && cont && trk[5:0] == BOUND_LAST_WORD && skip |=> o_rdy)
    else $error("boundary wait not skipped");
  chk_wrap_flow:
    assert property (@(posedge i_bclk) disable iff (!i_rst_n)
      o_rdy && i_cfg.mode != MODE_CONT && !i_ctl.oe_n && !i_ctl.ce_n
      && i_ctl.address_valid_strobe_n |=> o_rdy)
    else $error("wait inserted in wrap burst");
  chk_id_fixed:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $past(i_rst_n) |-> o_handshake_id == REDUCED_WS)
    else $error("handshake id wrong");
endmodule : flash_burst_checker
bind flash_burst_read_interface flash_burst_checker #(
  .REDUCED_WS(REDUCED_WS)
) u_checker (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bclk(i_bclk), .i_addr(i_addr),
  .i_ctl(i_ctl), .i_cfg(i_cfg), .i_bank_busy(i_bank_busy), .o_dq(o_dq),
  .o_rdy(o_rdy), .o_rdy_oe(o_rdy_oe), .o_handshake_id(o_handshake_id)
);
`default_nettype wire

/* File: testbench/flash_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input  wire logic                               i_rdy,
  input  wire logic [flash_burst_pkg::DATA_W-1:0] i_dq,
  output logic                                    o_bclk,
  output logic      [flash_burst_pkg::ADDR_W-1:0] o_addr,
  output var flash_burst_pkg::bus_ctl_t           o_ctl
);
  import flash_burst_pkg::*;
  logic [DATA_W-1:0] words[$];
  int                stuck;
  initial
  begin
    o_bclk = 1'b0;
    o_addr = '0;
    o_ctl  = 4'hf;
    stuck  = 0;
  end
  // Clock runs inside frames and for two edges after deselect; pins move 0.7 ns after each rising edge
  task automatic tick;
    #5.3 o_bclk = 1'b0;
    #6 o_bclk = 1'b1;
    #0.7;
  endtask : tick
  task automatic start(input logic [ADDR_W-1:0] a);
    o_addr = a;
    o_ctl  = 4'h2;
    tick();
    o_ctl.address_valid_strobe_n = 1'b1;
    o_addr = ~a; // Released pins must not keep the last address
  endtask : start
  task automatic get(input int n);
    int t;
    t = 0;
    o_ctl.oe_n = 1'b0;
    while (n > 0 && t < 300)
    begin
      tick();
      t++;
      if (i_rdy === 1'b1)
      begin
        words.push_back(i_dq);
        n--;
      end
    end
    if (n > 0)
      stuck++;
  endtask : get
  task automatic pause(input int k);
    o_ctl.oe_n = 1'b1;
    repeat (k) tick();
  endtask : pause
  task automatic stop;
    o_ctl = 4'hf;
    repeat (2) tick();
    #5.3 o_bclk = 1'b0;
  endtask : stop
  task automatic pins(input logic [ADDR_W-1:0] a);
    o_addr = a;
    o_ctl  = 4'h2;
  endtask : pins
endmodule : flash_host_model
`default_nettype wire

/* File: testbench/flash_burst_read_interface_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_burst_read_interface_tb;
  import flash_burst_pkg::*;
  logic              mclk;
  logic              rst_n;
  logic              bclk;
  logic [ADDR_W-1:0] addr;
  bus_ctl_t          ctl;
  cfg_t              cfg;
  logic              cfg_load;
  logic [BANKS-1:0]  busy;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] dq;
  logic              dq_oe;
  logic              rdy;
  logic              rdy_oe;
  logic              hs_id;
  int                num_errors;
  int                n_checks;
  flash_burst_read_interface #(.REDUCED_WS(1'b0), .MEM_AW(8)) uut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_bclk(bclk), .i_addr(addr), .i_ctl(ctl),
    .i_cfg(cfg), .i_cfg_load(cfg_load), .i_bank_busy(busy), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_dq(dq), .o_dq_oe(dq_oe),
    .o_rdy(rdy), .o_rdy_oe(rdy_oe), .o_handshake_id(hs_id)
  );
  flash_host_model host (.i_rdy(rdy), .i_dq(dq), .o_bclk(bclk), .o_addr(addr), .o_ctl(ctl));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [DATA_W-1:0] mem_word(input logic [ADDR_W-1:0] a);
    mem_word = {8'h5a, a[7:0]};
  endfunction : mem_word
  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a, input burst_mode_t m);
    logic [ADDR_W-1:0] k;
    k = (m == MODE_CONT) ? '1 : (22'h4 << m) - 22'h1;
    step = (a & ~k) | ((a + 22'h1) & k);
  endfunction : step
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic load(input burst_mode_t m, input logic [3:0] ws);
    @(posedge mclk);
    #1;
    cfg      = '{1'b1, 1'b0, 1'b0, m, ws};
    cfg_load = 1'b1;
    @(posedge mclk);
    #1;
    cfg_load = 1'b0;
    host.stop(); // Link side needs two edges to see the new setting
  endtask : load
  task automatic expect_seq(input logic [ADDR_W-1:0] a, input burst_mode_t m, input int n);
    logic [ADDR_W-1:0] x;
    x = a;
    if (host.stuck != 0)
    begin
      num_errors++;
      test_done();
    end
    for (int i = 0; i < n; i++)
    begin
      check("burst word", host.words[i], mem_word(x));
      x = step(x, m);
    end
  endtask : expect_seq
  task automatic burst(input burst_mode_t m, input logic [3:0] ws,
                       input logic [ADDR_W-1:0] a, input int n);
    load(m, ws);
    host.words.delete();
    host.start(a);
    host.get(n);
    host.stop();
    expect_seq(a, m, n);
    $display("test burst from %h done", a);
  endtask : burst
  initial
  begin
    #200000;
    num_errors++;
    test_done();
  end
  initial
  begin
    {rst_n, cfg, cfg_load, busy, wr_en, wr_addr, wr_data} = '0;
    num_errors = 0;
    n_checks   = 0;
    host.stop();
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge mclk);
    check("handshake id", DATA_W'(hs_id), 16'h0000);
    for (int i = 0; i < 256; i++)
    begin
      @(posedge mclk);
      #1;
      wr_en   = 1'b1;
      wr_addr = ADDR_W'(i);
      wr_data = mem_word(ADDR_W'(i));
    end
    @(posedge mclk);
    #1;
    wr_en = 1'b0;
    host.pins(22'h000033);
    repeat (10) @(posedge mclk);
    check("async data", dq, mem_word(22'h000033));
    check("async enable", DATA_W'(dq_oe), 16'h0001);
    host.stop();
    $display("test async read done");
    burst(MODE_CONT, 4'h2, 22'h00003c, 8);
    host.pins(22'h000033);
    repeat (10) @(posedge mclk);
    check("async refused", DATA_W'(dq_oe), 16'h0000);
    host.stop();
    burst(MODE_CONT, 4'h0, 22'h00003e, 6);
    burst(MODE_CONT, 4'hf, 22'h07fffd, 6);
    burst(MODE_CONT, 4'h2, 22'h3ffffc, 8);
    burst(MODE_WRAP8, 4'h2, 22'h000039, 10);
    burst(MODE_WRAP16, 4'h3, 22'h00003d, 18);
    burst(MODE_WRAP32, 4'h1, 22'h00002e, 34);
    load(MODE_CONT, 4'h2);
    host.words.delete();
    host.start(22'h000020);
    host.pause(3);
    host.get(3);
    host.pause(4);
    check("ready enable", DATA_W'(rdy_oe), 16'h0001);
    check("ready suspended", DATA_W'(rdy), 16'h0000);
    host.get(3);
    host.stop();
    expect_seq(22'h000020, MODE_CONT, 6);
    $display("test suspend done");
    @(posedge mclk);
    #1;
    busy = 4'h2;
    load(MODE_CONT, 4'h2);
    host.words.delete();
    host.start(22'h07fffc);
    host.get(6);
    host.stop();
    expect_seq(22'h07fffc, MODE_CONT, 4);
    check("status word", host.words[4], STATUS_WORD);
    check("status held", host.words[5], STATUS_WORD);
    @(posedge mclk);
    #1;
    busy = 4'h0;
    burst(MODE_CONT, 4'h2, 22'h000010, 4);
    test_done();
  end
endmodule : flash_burst_read_interface_tb
`default_nettype wire
